// ---- rtl/two_wire_pkg.sv ----
// shared constants and types for both ends of the two-wire serial bus
package two_wire_pkg;

  // master bit timing: quarter of a bus clock period in core cycles
  localparam int CORE_PERIOD_NS = 5;
  localparam int SCL_PERIOD_NS = 2500;
  localparam logic [7:0] QTR_CYCLES = 8'((SCL_PERIOD_NS + 4 * CORE_PERIOD_NS - 1) / (4 * CORE_PERIOD_NS));

  // packet layout
  localparam logic [3:0] PKT_BITS = 4'h8;
  localparam logic [6:0] GCALL_ADDR = 7'h00;
  localparam logic [4:0] TEN_PREFIX = 5'h1e;

  // event and flag positions
  localparam int EV_ADDR = 0;
  localparam int EV_DATA = 1;
  localparam int EV_STOP = 2;
  localparam int EV_RSTART = 3;
  localparam int EV_BUSERR = 4;
  localparam int EV_ARB = 5;
  localparam int EV_COLL = 6;
  localparam int EV_NUM = 7;
  localparam logic [EV_NUM-1:0] FLAGS_RST = 7'h00;

  // address configuration word layout
  localparam int CFG_OWN_LSB = 0;
  localparam int CFG_ALT_LSB = 7;
  localparam int CFG_TEN_LSB = 14;
  localparam int CFG_HW = 16;
  localparam int CFG_GC = 17;
  localparam int CFG_MM = 18;
  localparam int CFG_TE = 19;
  localparam int CFG_W = 20;

  // slave bus engine states
  typedef enum logic [2:0] {
    S_IDLE = 3'h0,
    S_ADDR = 3'h1,
    S_AACK = 3'h3,
    S_RX = 3'h2,
    S_RACK = 3'h6,
    S_TX = 3'h7,
    S_TACK = 3'h5,
    S_SKIP = 3'h4
  } slv_state_t;

  // master sequencer states
  typedef enum logic [1:0] {
    M_IDLE = 2'h0,
    M_START = 2'h1,
    M_BIT = 2'h3,
    M_STOP = 2'h2
  } mst_state_t;

  // master commands
  typedef enum logic [1:0] {
    CMD_START = 2'h0,
    CMD_WRITE = 2'h1,
    CMD_READ = 2'h3,
    CMD_STOP = 2'h2
  } cmd_t;

endpackage

// ---- rtl/two_wire_if.sv ----
// open-drain two-wire bus carrier joining master and slave ends
`timescale 1ns/1ps
`default_nettype none
interface two_wire_if;
  logic scl_line;
  logic sda_line;
  logic m_scl_out;
  logic m_scl_oe;
  logic m_sda_out;
  logic m_sda_oe;
  logic s_scl_out;
  logic s_scl_oe;
  logic s_sda_out;
  logic s_sda_oe;

  // wired-and with pull-ups: a line is low while any end enables its driver with a low output
  assign scl_line = ~((m_scl_oe & ~m_scl_out) | (s_scl_oe & ~s_scl_out));
  assign sda_line = ~((m_sda_oe & ~m_sda_out) | (s_sda_oe & ~s_sda_out));

  modport master_mp (
    input scl_line,
    input sda_line,
    output m_scl_out,
    output m_scl_oe,
    output m_sda_out,
    output m_sda_oe
  );

  modport slave_mp (
    input scl_line,
    input sda_line,
    output s_scl_out,
    output s_scl_oe,
    output s_sda_out,
    output s_sda_oe
  );
endinterface
`default_nettype wire

// ---- rtl/two_wire_master.sv ----
// bus master end: makes the bus clock by division and runs start, byte and stop commands
`timescale 1ns/1ps
`default_nettype none
module two_wire_master (
  // clock and reset
  input wire logic core_clk_in,
  input wire logic rst_in,
  // bus pins
  two_wire_if.master_mp bus,
  // command port
  input wire logic cmd_valid_in,
  input wire two_wire_pkg::cmd_t cmd_in,
  input wire logic [7:0] wdata_in,
  input wire logic rd_ack_in,
  output logic cmd_ready_out,
  output logic done_out,
  output logic [7:0] rdata_out,
  output logic nack_out
);
  import two_wire_pkg::*;

  mst_state_t st_q, st_d;
  cmd_t cmd_q, cmd_d;
  logic [1:0] ph_q, ph_d;
  logic [7:0] tick_q, tick_d;
  logic [3:0] bit_q, bit_d;
  logic [8:0] tx_q, tx_d, rx_q, rx_d;
  logic scl_oe_q, scl_oe_d, sda_oe_q, sda_oe_d;
  logic rdy_q, rdy_d, done_q, done_d, nack_q, nack_d;
  logic [7:0] rdata_q, rdata_d;
  logic [1:0] pin_s1, pin_s2;
  logic adv;

  // -------------------------------------------------------------------------
  // pin synchronisers and outputs
  // -------------------------------------------------------------------------
  always_ff @(posedge core_clk_in)
  begin
    pin_s1 <= {bus.scl_line, bus.sda_line};
    pin_s2 <= pin_s1;
  end

  // pull low or release only, never drive high
  assign bus.m_scl_out = 1'b0;
  assign bus.m_sda_out = 1'b0;
  assign bus.m_scl_oe = scl_oe_q;
  assign bus.m_sda_oe = sda_oe_q;
  assign cmd_ready_out = rdy_q;
  assign done_out = done_q;
  assign rdata_out = rdata_q;
  assign nack_out = nack_q;

  // -------------------------------------------------------------------------
  // sequencer: four quarter phases per bit, start and stop
  // -------------------------------------------------------------------------
  always_comb
  begin
    st_d = st_q;
    cmd_d = cmd_q;
    ph_d = ph_q;
    bit_d = bit_q;
    tx_d = tx_q;
    rx_d = rx_q;
    scl_oe_d = scl_oe_q;
    sda_oe_d = sda_oe_q;
    rdy_d = rdy_q;
    done_d = 1'b0;
    nack_d = nack_q;
    rdata_d = rdata_q;
    // phase 1 releases the clock and waits while anyone stretches it
    adv = (tick_q == QTR_CYCLES - 8'h01) && !(ph_q == 2'h1 && !pin_s2[1]);
    tick_d = adv ? 8'h00 : ((tick_q == QTR_CYCLES - 8'h01) ? tick_q : tick_q + 8'h01);
    unique case (st_q)
      M_IDLE:
      begin
        tick_d = 8'h00;
        if (cmd_valid_in && rdy_q)
        begin
          cmd_d = cmd_in;
          ph_d = 2'h0;
          bit_d = 4'h0;
          rdy_d = 1'b0;
          // eight bits msb first, then the ack bit
          tx_d = (cmd_in == CMD_WRITE) ? {wdata_in, 1'b1} : {8'hff, ~rd_ack_in};
          unique case (cmd_in)
            CMD_START:
            begin
              st_d = M_START;
              sda_oe_d = 1'b0;
            end
            CMD_STOP:
            begin
              st_d = M_STOP;
              sda_oe_d = 1'b1;
            end
            CMD_WRITE, CMD_READ:
            begin
              st_d = M_BIT;
              sda_oe_d = (cmd_in == CMD_WRITE) ? ~wdata_in[7] : 1'b0;
            end
          endcase
        end
      end
      M_START, M_STOP:
      begin
        if (adv)
        begin
          ph_d = ph_q + 2'h1;
          unique case (ph_q)
            2'h0: scl_oe_d = 1'b0;
            // data falls with clock high for start, rises for stop
            2'h1: sda_oe_d = (st_q == M_START);
            2'h2: scl_oe_d = (st_q == M_START);
            2'h3:
            begin
              st_d = M_IDLE;
              rdy_d = 1'b1;
              done_d = 1'b1;
            end
          endcase
        end
      end
      M_BIT:
      begin
        if (adv)
        begin
          ph_d = ph_q + 2'h1;
          unique case (ph_q)
            2'h0: scl_oe_d = 1'b0;
            2'h1: rx_d = {rx_q[7:0], pin_s2[0]};
            2'h2: scl_oe_d = 1'b1;
            2'h3:
            begin
              // nine clocks per packet, the ninth carries the ack
              if (bit_q == PKT_BITS)
              begin
                st_d = M_IDLE;
                rdy_d = 1'b1;
                done_d = 1'b1;
                rdata_d = rx_q[8:1];
                nack_d = rx_q[0];
              end
              else
              begin
                bit_d = bit_q + 4'h1;
                tx_d = {tx_q[7:0], 1'b1};
                sda_oe_d = ~tx_q[7];
              end
            end
          endcase
        end
      end
    endcase
  end

  // sequencer registers
  always_ff @(posedge core_clk_in)
  begin
    if (rst_in)
    begin
      st_q <= M_IDLE;
      cmd_q <= CMD_START;
      ph_q <= 2'h0;
      tick_q <= 8'h00;
      bit_q <= 4'h0;
      tx_q <= 9'h1ff;
      rx_q <= 9'h000;
      scl_oe_q <= 1'b0;
      sda_oe_q <= 1'b0;
      rdy_q <= 1'b1;
      done_q <= 1'b0;
      nack_q <= 1'b0;
      rdata_q <= 8'h00;
    end
    else
    begin
      st_q <= st_d;
      cmd_q <= cmd_d;
      ph_q <= ph_d;
      tick_q <= tick_d;
      bit_q <= bit_d;
      tx_q <= tx_d;
      rx_q <= rx_d;
      scl_oe_q <= scl_oe_d;
      sda_oe_q <= sda_oe_d;
      rdy_q <= rdy_d;
      done_q <= done_d;
      nack_q <= nack_d;
      rdata_q <= rdata_d;
    end
  end
endmodule
`default_nettype wire

// ---- rtl/two_wire_slave.sv ----
// slave end: bus engine on the link clock, software flags and handshake on the core clock
//
// Summary of operation
// - data falling, clock high means start
// - data rising, clock high means stop
// - start inside transaction is repeated start
// - data changes only while clock low
// - eight bits msb first, then ack
// - ack in ninth clock: low acks
// - master sends address and direction first
// - ack own address, else release and wait
// - one address packet per start
// - direction low: slave receives data
// - direction high: slave sends data
// - data packets nine bits, direction fixed
// - any number of data packets allowed
// - master stops after slave nack
// - master nacks last read byte
// - anyone may stretch clock low
// - match seven-bit, general call, ten-bit
// - second address or address mask
// - matching can be handed to software
// - engine keeps running, match wakes device
// - arbitration, error, collision, hold flags
// - lines only pulled low or released
// - pending flag holds clock low
`timescale 1ns/1ps
`default_nettype none
module two_wire_slave (
  // core clock domain
  input wire logic core_clk_in,
  input wire logic rst_in,
  // link clock domain
  input wire logic link_clk_in,
  // bus pins
  two_wire_if.slave_mp bus,
  // address configuration, change only while the bus is idle
  input wire logic [6:0] own_addr_in,
  input wire logic [6:0] alt_addr_in,
  input wire logic [1:0] ten_hi_in,
  input wire logic hw_match_in,
  input wire logic gcall_en_in,
  input wire logic mask_mode_in,
  input wire logic ten_en_in,
  // software side
  input wire logic [two_wire_pkg::EV_NUM-1:0] flag_clr_in,
  input wire logic ack_in,
  input wire logic [7:0] tx_data_in,
  output logic [two_wire_pkg::EV_NUM-1:0] flags_out,
  output logic [7:0] rx_data_out,
  output logic dir_out,
  output logic hold_out,
  output logic wake_out
);
  import two_wire_pkg::*;

  // address recognition against the synchronised configuration word
  function automatic logic addr_match(input logic [6:0] a, input logic [CFG_W-1:0] c);
    logic [6:0] own;
    logic [6:0] alt;
    logic hit;
    own = c[CFG_OWN_LSB +: 7];
    alt = c[CFG_ALT_LSB +: 7];
    hit = (a == own);
    hit = hit | (c[CFG_GC] && a == GCALL_ADDR);
    hit = hit | (c[CFG_TE] && a[6:2] == TEN_PREFIX && a[1:0] == c[CFG_TEN_LSB +: 2]);
    hit = hit | (c[CFG_MM] ? ((a | alt) == (own | alt)) : (a == alt));
    return hit | ~c[CFG_HW];
  endfunction

  // link domain state
  slv_state_t st_q, st_d;
  logic [3:0] cnt_q, cnt_d;
  logic [7:0] sh_q, sh_d, rxb_q, rxb_d;
  logic dir_q, dir_d, intr_q, intr_d, sda_oe_q, sda_oe_d, scl_oe_q, scl_oe_d;
  logic hreq_q, hreq_d, pend_q;
  logic [EV_NUM-1:0] ev_q, ev_d, evp;
  logic [1:0] lrst_s, pin_s1, pin_s2, pin_p;
  logic [CFG_W-1:0] cfg_s1, cfg_s2;
  logic ack_s1, ack_s2;
  logic scl, sda, rise, fall, start_c, stop_c, pending, done_c, mid_byte;
  // core domain state
  logic [EV_NUM-1:0] flags_q, flags_d, ev_s1, ev_s2, ev_p, edge_c;
  logic ackt_q, ackt_d, ack_q, ack_d, dir_o_q, dir_o_d, hold_q, hold_d, wake_q, wake_d, rel_c;
  logic [7:0] tx_q, tx_d, rx_q, rx_d;

  // -------------------------------------------------------------------------
  // link domain: synchronisers
  // -------------------------------------------------------------------------
  always_ff @(posedge link_clk_in)
  begin
    lrst_s <= {lrst_s[0], rst_in};
    pin_s1 <= {bus.scl_line, bus.sda_line};
    pin_s2 <= pin_s1;
    pin_p <= pin_s2;
    cfg_s1 <= {ten_en_in, mask_mode_in, gcall_en_in, hw_match_in, ten_hi_in, alt_addr_in, own_addr_in};
    cfg_s2 <= cfg_s1;
    ack_s1 <= ackt_q;
    ack_s2 <= ack_s1;
  end

  // bus conditions and clock edges
  assign scl = pin_s2[1];
  assign sda = pin_s2[0];
  assign rise = scl & ~pin_p[1];
  assign fall = ~scl & pin_p[1];
  assign start_c = scl & pin_p[1] & pin_p[0] & ~sda;
  assign stop_c = scl & pin_p[1] & ~pin_p[0] & sda;
  assign pending = hreq_q ^ ack_s2;
  assign done_c = pend_q & ~pending;
  assign mid_byte = (st_q == S_ADDR || st_q == S_RX || st_q == S_TX) && cnt_q > 4'h1; // first clock may be start or stop

  // open-drain pins: only the enables ever change
  assign bus.s_scl_out = 1'b0;
  assign bus.s_sda_out = 1'b0;
  assign bus.s_scl_oe = scl_oe_q;
  assign bus.s_sda_oe = sda_oe_q;

  // -------------------------------------------------------------------------
  // link domain: bus engine
  // -------------------------------------------------------------------------
  always_comb
  begin
    st_d = st_q;
    cnt_d = cnt_q;
    sh_d = sh_q;
    rxb_d = rxb_q;
    dir_d = dir_q;
    intr_d = intr_q;
    sda_oe_d = sda_oe_q;
    hreq_d = hreq_q;
    evp = '0;
    // clock held low until software answers, one clock more so a new data bit settles
    scl_oe_d = pending | done_c;
    if (start_c)
    begin
      evp[EV_RSTART] = intr_q;
      evp[EV_BUSERR] = mid_byte;
      evp[EV_COLL] = sda_oe_q;
      st_d = S_ADDR;
      cnt_d = 4'h0;
      intr_d = 1'b1;
      sda_oe_d = 1'b0;
    end
    else if (stop_c)
    begin
      evp[EV_BUSERR] = mid_byte | (st_q == S_ADDR && cnt_q <= 4'h1);
      evp[EV_STOP] = intr_q;
      st_d = S_IDLE;
      intr_d = 1'b0;
      sda_oe_d = 1'b0;
    end
    else
    begin
      unique case (st_q)
        S_IDLE, S_SKIP: ;
        S_ADDR, S_RX:
        begin
          if (rise)
          begin
            sh_d = {sh_q[6:0], sda};
            cnt_d = cnt_q + 4'h1;
          end
          else if (fall && cnt_q == PKT_BITS)
          begin
            cnt_d = 4'h0;
            if (st_q == S_RX || addr_match(sh_q[7:1], cfg_s2))
            begin
              rxb_d = sh_q;
              dir_d = (st_q == S_ADDR) ? sh_q[0] : dir_q;
              evp[EV_ADDR] = (st_q == S_ADDR);
              evp[EV_DATA] = (st_q == S_RX);
              hreq_d = ~hreq_q;
              st_d = (st_q == S_ADDR) ? S_AACK : S_RACK;
            end
            else
            begin
              st_d = S_SKIP;
            end
          end
        end
        S_AACK, S_RACK:
        begin
          if (done_c)
          begin
            sda_oe_d = ack_q;
          end
          else if (fall)
          begin
            sda_oe_d = 1'b0;
            cnt_d = 4'h0;
            if (!ack_q)
            begin
              st_d = S_SKIP;
            end
            else if (st_q == S_AACK && dir_q)
            begin
              evp[EV_DATA] = 1'b1;
              hreq_d = ~hreq_q;
              st_d = S_TX;
            end
            else
            begin
              st_d = S_RX;
            end
          end
        end
        S_TX:
        begin
          if (done_c)
          begin
            sh_d = tx_q;
            sda_oe_d = ~tx_q[7];
            cnt_d = 4'h0;
          end
          else if (rise)
          begin
            if (!sda_oe_q && !sda)
            begin
              evp[EV_ARB] = 1'b1;
              st_d = S_SKIP;
            end
            else
            begin
              cnt_d = cnt_q + 4'h1;
            end
          end
          else if (fall)
          begin
            if (cnt_q == PKT_BITS)
            begin
              sda_oe_d = 1'b0;
              st_d = S_TACK;
            end
            else
            begin
              sh_d = {sh_q[6:0], 1'b0};
              sda_oe_d = ~sh_q[6];
            end
          end
        end
        S_TACK:
        begin
          if (rise)
          begin
            sh_d[0] = sda;
          end
          else if (fall)
          begin
            cnt_d = 4'h0;
            if (sh_q[0])
            begin
              st_d = S_SKIP;
            end
            else
            begin
              evp[EV_DATA] = 1'b1;
              hreq_d = ~hreq_q;
              st_d = S_TX;
            end
          end
        end
      endcase
    end
    ev_d = ev_q ^ evp;
  end

  // bus engine registers
  always_ff @(posedge link_clk_in)
  begin
    if (lrst_s[1])
    begin
      st_q <= S_IDLE;
      cnt_q <= 4'h0;
      sh_q <= 8'h00;
      rxb_q <= 8'h00;
      dir_q <= 1'b0;
      intr_q <= 1'b0;
      sda_oe_q <= 1'b0;
      scl_oe_q <= 1'b0;
      hreq_q <= 1'b0;
      pend_q <= 1'b0;
      ev_q <= FLAGS_RST;
    end
    else
    begin
      st_q <= st_d;
      cnt_q <= cnt_d;
      sh_q <= sh_d;
      rxb_q <= rxb_d;
      dir_q <= dir_d;
      intr_q <= intr_d;
      sda_oe_q <= sda_oe_d;
      scl_oe_q <= scl_oe_d;
      hreq_q <= hreq_d;
      pend_q <= pending;
      ev_q <= ev_d;
    end
  end

  // -------------------------------------------------------------------------
  // core domain: event toggles, sticky flags and release handshake
  // -------------------------------------------------------------------------
  always_ff @(posedge core_clk_in)
  begin
    ev_s1 <= ev_q;
    ev_s2 <= ev_s1;
  end

  assign edge_c = ev_s2 ^ ev_p;
  assign rel_c = |(flags_q[EV_DATA:EV_ADDR] & flag_clr_in[EV_DATA:EV_ADDR]);
  assign flags_out = flags_q;
  assign rx_data_out = rx_q;
  assign dir_out = dir_o_q;
  assign hold_out = hold_q;
  assign wake_out = wake_q;

  // set wins over a clear in the same cycle
  always_comb
  begin
    flags_d = (flags_q & ~flag_clr_in) | edge_c;
    ackt_d = ackt_q ^ rel_c;
    ack_d = rel_c ? ack_in : ack_q;
    tx_d = rel_c ? tx_data_in : tx_q;
    rx_d = (edge_c[EV_ADDR] | edge_c[EV_DATA]) ? rxb_q : rx_q;
    dir_o_d = edge_c[EV_ADDR] ? dir_q : dir_o_q;
    hold_d = |flags_d[EV_DATA:EV_ADDR];
    wake_d = edge_c[EV_ADDR];
  end

  // core registers
  always_ff @(posedge core_clk_in)
  begin
    if (rst_in)
    begin
      ev_p <= FLAGS_RST;
      flags_q <= FLAGS_RST;
      ackt_q <= 1'b0;
      ack_q <= 1'b0;
      tx_q <= 8'h00;
      rx_q <= 8'h00;
      dir_o_q <= 1'b0;
      hold_q <= 1'b0;
      wake_q <= 1'b0;
    end
    else
    begin
      ev_p <= ev_s2;
      flags_q <= flags_d;
      ackt_q <= ackt_d;
      ack_q <= ack_d;
      tx_q <= tx_d;
      rx_q <= rx_d;
      dir_o_q <= dir_o_d;
      hold_q <= hold_d;
      wake_q <= wake_d;
    end
  end
endmodule
`default_nettype wire

// ---- bench/two_wire_bus_slave_monitor.sv ----
// checker watching both ends of the two-wire bus
`timescale 1ns/1ps
`default_nettype none
module two_wire_bus_slave_monitor (
  // clocks and reset
  input wire logic core_clk_in,
  input wire logic link_clk_in,
  input wire logic rst_in,
  // wired lines and the drivers of both ends
  input wire logic scl_line,
  input wire logic sda_line,
  input wire logic m_scl_out,
  input wire logic m_scl_oe,
  input wire logic m_sda_out,
  input wire logic m_sda_oe,
  input wire logic s_scl_out,
  input wire logic s_scl_oe,
  input wire logic s_sda_out,
  input wire logic s_sda_oe
);
  // ----------------------------------------
  // line history and counters
  // ----------------------------------------
  logic scl_q, sda_q, start_w;
  logic [7:0] hi_q, hi_d;
  logic [3:0] bit_q, bit_d;
  assign start_w = scl_line && scl_q && sda_q && !sda_line;
  // clock-high length and clock rises since the last start
  always_comb
  begin
    hi_d = scl_line ? hi_q + {7'h00, hi_q != 8'hff} : 8'h00;
    bit_d = bit_q + {3'h0, scl_line && !scl_q && bit_q != 4'hf};
    if (start_w)
      bit_d = 4'h0;
  end
  // register history; bit count parks at its top until a start
  always_ff @(posedge core_clk_in)
  begin
    scl_q <= rst_in ? 1'b1 : scl_line;
    sda_q <= rst_in ? 1'b1 : sda_line;
    hi_q <= rst_in ? 8'h00 : hi_d;
    bit_q <= rst_in ? 4'hf : bit_d;
  end
  // ----------------------------------------
  // properties
  // ----------------------------------------
  property p_slv_pull;
    @(posedge core_clk_in) disable iff (rst_in) !((s_scl_oe && s_scl_out) || (s_sda_oe && s_sda_out));
  endproperty
  a_slv_pull: assert property (p_slv_pull) else $error("slave drives a line high");
  property p_mst_pull;
    @(posedge core_clk_in) disable iff (rst_in) !((m_scl_oe && m_scl_out) || (m_sda_oe && m_sda_out));
  endproperty
  a_mst_pull: assert property (p_mst_pull) else $error("master drives a line high");
  property p_sda_hold;
    @(posedge core_clk_in) disable iff (rst_in) (scl_line && scl_q) |-> $stable(s_sda_oe);
  endproperty
  a_sda_hold: assert property (p_sda_hold) else $error("slave data moved while clock high");
  property p_sda_launch;
    @(posedge link_clk_in) disable iff (rst_in) $changed(s_sda_oe) |-> !scl_line;
  endproperty
  a_sda_launch: assert property (p_sda_launch) else $error("slave data launched with clock high");
  property p_stretch;
    @(posedge core_clk_in) disable iff (rst_in) $rose(s_scl_oe) |-> !$past(scl_line);
  endproperty
  a_stretch: assert property (p_stretch) else $error("slave pulled a high clock");
  property p_mst_wait;
    @(posedge core_clk_in) disable iff (rst_in) $rose(m_scl_oe) |-> $past(scl_line);
  endproperty
  a_mst_wait: assert property (p_mst_wait) else $error("master cut a stretched clock");
  property p_high_len;
    @(posedge core_clk_in) disable iff (rst_in) $fell(scl_line) |-> hi_q >= 8'h64;
  endproperty
  a_high_len: assert property (p_high_len) else $error("clock high period too short");
  property p_addr_quiet;
    @(posedge core_clk_in) disable iff (rst_in) (scl_line && scl_q && bit_q >= 4'h1 && bit_q <= 4'h8) |-> !s_sda_oe;
  endproperty
  a_addr_quiet: assert property (p_addr_quiet) else $error("slave drove data in address bits");
  property p_start_quiet;
    @(posedge core_clk_in) disable iff (rst_in) start_w |=> (!s_sda_oe && !s_scl_oe) [*8];
  endproperty
  a_start_quiet: assert property (p_start_quiet) else $error("slave busy after start");
  // main scenarios reached
  c_start: cover property (@(posedge core_clk_in) disable iff (rst_in) start_w);
  c_stretch: cover property (@(posedge core_clk_in) disable iff (rst_in) $rose(s_scl_oe));
  c_ack: cover property (@(posedge core_clk_in) disable iff (rst_in) scl_line && s_sda_oe && bit_q == 4'h9);
endmodule
`default_nettype wire

// ---- bench/two_wire_bus_slave_tb.sv ----
// testbench: master and slave ends joined on one two-wire bus
`timescale 1ns/1ps
`default_nettype none
module two_wire_bus_slave_tb;
  import two_wire_pkg::*;
  // ----------------------------------------
  // stimulus and observed signals
  // ----------------------------------------
  typedef struct packed {cmd_t c; logic [7:0] w; logic ra; logic sa; logic en; logic [7:0] er;} row_t;
  logic core_clk_in = 1'b0, link_clk_in = 1'b0, rst_in = 1'b1;
  logic cmd_valid_in = 1'b0, rd_ack_in = 1'b1, ack_in = 1'b1, hw_match = 1'b1, gcall_en = 1'b1, sw_ack = 1'b1;
  cmd_t cmd_in = CMD_START;
  logic [7:0] wdata_in = 8'h00, tx_data_in = 8'h00, rdata_out, rx_data_out;
  logic cmd_ready_out, done_out, nack_out, dir_out, hold_out, wake_out;
  logic [EV_NUM-1:0] flags_out, resp_clr = 7'h00, tb_clr = 7'h00;
  int fail_count = 0, n_tests = 0, addr_cnt = 0, wake_cnt = 0, stall = 0;
  logic [7:0] rxq[$];
  // one master command per row with the answer it should give
  row_t rows [16] = '{
    '{CMD_START, 8'h00, 1'b1, 1'b1, 1'b0, 8'h00},
    '{CMD_WRITE, 8'hA4, 1'b1, 1'b1, 1'b0, 8'hA4},
    '{CMD_WRITE, 8'hA5, 1'b1, 1'b1, 1'b0, 8'hA5},
    '{CMD_WRITE, 8'h5A, 1'b1, 1'b0, 1'b1, 8'h5A},
    '{CMD_STOP, 8'h00, 1'b1, 1'b1, 1'b0, 8'h00},
    '{CMD_START, 8'h00, 1'b1, 1'b1, 1'b0, 8'h00},
    '{CMD_WRITE, 8'hA5, 1'b1, 1'b1, 1'b0, 8'hA5},
    '{CMD_READ, 8'h00, 1'b1, 1'b1, 1'b0, 8'h96},
    '{CMD_READ, 8'h00, 1'b0, 1'b1, 1'b1, 8'h96},
    '{CMD_START, 8'h00, 1'b1, 1'b1, 1'b0, 8'h00},
    '{CMD_WRITE, 8'h00, 1'b1, 1'b1, 1'b0, 8'h00},
    '{CMD_START, 8'h00, 1'b1, 1'b1, 1'b0, 8'h00},
    '{CMD_WRITE, 8'h32, 1'b1, 1'b1, 1'b0, 8'h32},
    '{CMD_START, 8'h00, 1'b1, 1'b1, 1'b0, 8'h00},
    '{CMD_WRITE, 8'h56, 1'b1, 1'b1, 1'b1, 8'h56},
    '{CMD_STOP, 8'h00, 1'b1, 1'b1, 1'b0, 8'h00}};
  // ----------------------------------------
  // clocks, ends and checker
  // ----------------------------------------
  always #2.5 core_clk_in = ~core_clk_in;
  initial
  begin
    #1.3;
    forever #40 link_clk_in = ~link_clk_in;
  end
  two_wire_if two_wire_if_i ();
  two_wire_master two_wire_master_i (.core_clk_in(core_clk_in), .rst_in(rst_in), .bus(two_wire_if_i.master_mp),
    .cmd_valid_in(cmd_valid_in), .cmd_in(cmd_in), .wdata_in(wdata_in), .rd_ack_in(rd_ack_in),
    .cmd_ready_out(cmd_ready_out), .done_out(done_out), .rdata_out(rdata_out), .nack_out(nack_out));
  two_wire_slave two_wire_slave_i (.core_clk_in(core_clk_in), .rst_in(rst_in), .link_clk_in(link_clk_in),
    .bus(two_wire_if_i.slave_mp), .own_addr_in(7'h52), .alt_addr_in(7'h19), .ten_hi_in(2'h0),
    .hw_match_in(hw_match), .gcall_en_in(gcall_en), .mask_mode_in(1'b0), .ten_en_in(1'b0),
    .flag_clr_in(resp_clr | tb_clr), .ack_in(ack_in), .tx_data_in(tx_data_in), .flags_out(flags_out),
    .rx_data_out(rx_data_out), .dir_out(dir_out), .hold_out(hold_out), .wake_out(wake_out));
  two_wire_bus_slave_monitor two_wire_bus_slave_monitor_i (.core_clk_in(core_clk_in), .link_clk_in(link_clk_in),
    .rst_in(rst_in), .scl_line(two_wire_if_i.scl_line), .sda_line(two_wire_if_i.sda_line),
    .m_scl_out(two_wire_if_i.m_scl_out), .m_scl_oe(two_wire_if_i.m_scl_oe), .m_sda_out(two_wire_if_i.m_sda_out),
    .m_sda_oe(two_wire_if_i.m_sda_oe), .s_scl_out(two_wire_if_i.s_scl_out), .s_scl_oe(two_wire_if_i.s_scl_oe),
    .s_sda_out(two_wire_if_i.s_sda_out), .s_sda_oe(two_wire_if_i.s_sda_oe));
  // software: clears address and data flags after a stall that stretches the clock
  always @(negedge core_clk_in)
  begin
    resp_clr <= 7'h00;
    if (wake_out === 1'b1)
      wake_cnt <= wake_cnt + 1;
    if ((flags_out[EV_ADDR] | flags_out[EV_DATA]) === 1'b1 && resp_clr === 7'h00 && stall < 40)
      stall <= stall + 1;
    else if ((flags_out[EV_ADDR] | flags_out[EV_DATA]) === 1'b1 && resp_clr === 7'h00)
    begin
      stall <= 0;
      chk({6'h00, hold_out, two_wire_if_i.s_scl_oe}, 8'h03);
      resp_clr <= flags_out & 7'h03;
      ack_in <= sw_ack;
      tx_data_in <= 8'h96;
      addr_cnt <= addr_cnt + int'(flags_out[EV_ADDR]);
      if (flags_out[EV_DATA] && !dir_out)
        rxq.push_back(rx_data_out);
    end
  end
  // ----------------------------------------
  // tasks
  // ----------------------------------------
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_tests++;
    if (got !== exp)
    begin
      fail_count++;
      $display("unexpected at %0t ns: got %h, expected %h", $time, got, exp);
    end
  endtask
  // one command, valid for a single cycle, then bounded wait for done
  task automatic run_cmd(input row_t r);
    int n;
    n = 0;
    sw_ack = r.sa;
    @(negedge core_clk_in);
    cmd_in = r.c;
    wdata_in = r.w;
    rd_ack_in = r.ra;
    cmd_valid_in = 1'b1;
    @(negedge core_clk_in);
    cmd_valid_in = 1'b0;
    while (done_out !== 1'b1 && n < 20000)
    begin
      @(negedge core_clk_in);
      n++;
    end
    chk(8'(n < 20000), 8'h01);
    if (r.c == CMD_WRITE || r.c == CMD_READ)
    begin
      chk({7'h00, nack_out}, {7'h00, r.en});
      chk(rdata_out, r.er);
    end
  endtask
  task automatic clr_all;
    @(negedge core_clk_in);
    tb_clr = 7'h7f;
    @(negedge core_clk_in);
    tb_clr = 7'h00;
  endtask
  task automatic print_verdict;
    $display("checks %0d, mismatches %0d", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  // ----------------------------------------
  // sequence and watchdog
  // ----------------------------------------
  initial
  begin
    #400_000;
    fail_count++;
    $display("unexpected at %0t ns: run did not finish", $time);
    print_verdict();
  end
  initial
  begin
    repeat (8) @(posedge link_clk_in);
    @(negedge core_clk_in);
    rst_in = 1'b0;
    repeat (5) @(posedge link_clk_in);
    @(negedge core_clk_in);
    chk({1'b0, flags_out}, 8'h00);
    chk({6'h00, cmd_ready_out, hold_out}, 8'h02);
    foreach (rows[i])
      run_cmd(rows[i]);
    chk(8'(addr_cnt), 8'h04);
    chk(8'(wake_cnt), 8'h04);
    chk(rxq[0], 8'hA5);
    chk(rxq[1], 8'h5A);
    chk(8'(rxq.size()), 8'h02);
    chk({3'h0, flags_out[EV_COLL:EV_RSTART], flags_out[EV_STOP]}, 8'h03);
    clr_all();
    // start straight into stop is an error
    run_cmd(rows[0]);
    run_cmd(rows[4]);
    chk({7'h00, flags_out[EV_BUSERR]}, 8'h01);
    clr_all();
    // software decides on a foreign address and refuses it
    hw_match = 1'b0;
    run_cmd(rows[0]);
    run_cmd(row_t'{CMD_WRITE, 8'h56, 1'b1, 1'b0, 1'b1, 8'h56});
    run_cmd(rows[4]);
    chk(8'(addr_cnt), 8'h05);
    print_verdict();
  end
endmodule
`default_nettype wire
